//--- logic/irq_resolver_pkg.sv
// constants, types and helpers shared by the interrupt priority resolver
package irq_resolver_pkg;
    localparam int NSRC = 8;
    localparam int NCH  = 7;
    localparam int NEXT = 5;
    localparam int NTMR = 3;
    // request sources, index order is the tie-break order
    localparam logic [2:0] SRC_TMR = 3'h0;
    localparam logic [2:0] SRC_SRX = 3'h1;
    localparam logic [2:0] SRC_STX = 3'h2;
    localparam logic [2:0] SRC_EXE = 3'h3;
    localparam logic [2:0] SRC_EXA = 3'h4;
    localparam logic [2:0] SRC_EXB = 3'h5;
    localparam logic [2:0] SRC_EXC = 3'h6;
    localparam logic [2:0] SRC_EXD = 3'h7;
    // register offsets
    localparam logic [7:0] OFS_HDONE    = 8'h02;
    localparam logic [7:0] OFS_IMASK    = 8'h08;
    localparam logic [7:0] OFS_PMASK    = 8'h0A;
    localparam logic [7:0] OFS_INSRV    = 8'h0C;
    localparam logic [7:0] OFS_IREQ     = 8'h0E;
    localparam logic [7:0] OFS_TSTAT    = 8'h10;
    localparam logic [7:0] OFS_CTL_BASE = 8'h12;
    localparam logic [7:0] OFS_CTL_LAST = 8'h1E;
    // control word fields
    localparam int CTL_PRIO_LSB   = 0;
    localparam int CTL_MSK_BIT    = 3;
    localparam int CTL_CAS_BIT    = 5;
    localparam int CTL_SFNM_BIT   = 6;
    localparam int HDONE_NSPC_BIT = 15;
    // reset values
    localparam logic [2:0] PRIO_RST  = 3'h7;
    localparam logic [2:0] PMASK_RST = 3'h7;
    localparam logic [6:0] MSK_RST   = 7'h7F;
    // fixed interrupt types
    localparam logic [7:0] TYPE_T0  = 8'h08;
    localparam logic [7:0] TYPE_T1  = 8'h12;
    localparam logic [7:0] TYPE_T2  = 8'h13;
    localparam logic [7:0] TYPE_SRX = 8'h14;
    localparam logic [7:0] TYPE_STX = 8'h15;
    localparam logic [7:0] TYPE_EXE = 8'h11;
    localparam logic [7:0] TYPE_EXA = 8'h0C;
    localparam logic [7:0] TYPE_EXB = 8'h0D;
    localparam logic [7:0] TYPE_EXC = 8'h0E;
    localparam logic [7:0] TYPE_EXD = 8'h0F;

    typedef enum logic [1:0] {
        CS_IDLE  = 2'b00,
        CS_ARMED = 2'b01,
        CS_DRIVE = 2'b10
    } casc_state_t;

    // both serial sources share one control channel
    function automatic logic [2:0] chan_of(input logic [2:0] src);
        if (src == SRC_TMR || src == SRC_SRX)
            return src;
        return 3'(src - 3'h1);
    endfunction

    function automatic logic [7:0] type_of(input logic [2:0] src,
                                           input logic [1:0] tmr);
        case (src)
            SRC_TMR: return (tmr == 2'h0) ? TYPE_T0 :
                            (tmr == 2'h1) ? TYPE_T1 : TYPE_T2;
            SRC_SRX: return TYPE_SRX;
            SRC_STX: return TYPE_STX;
            SRC_EXE: return TYPE_EXE;
            SRC_EXA: return TYPE_EXA;
            SRC_EXB: return TYPE_EXB;
            SRC_EXC: return TYPE_EXC;
            default: return TYPE_EXD;
        endcase
    endfunction
endpackage

//--- logic/interrupt_priority_resolver.sv
// priority resolution, acknowledge and cascade logic of the interrupt unit
`timescale 1ns/1ps
// ============================================================
// ============================================================
module interrupt_priority_resolver (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [2:0]  tmr_evt,
    input  wire logic        ser_rx_evt,
    input  wire logic        ser_tx_evt,
    input  wire logic        ext_irq_pin_a,
    input  wire logic        ext_irq_pin_b,
    input  wire logic        ext_irq_pin_c,
    input  wire logic        ext_irq_pin_d,
    input  wire logic        ext_irq_pin_e,
    output logic             cascade_ack_out_a,
    output logic             cascade_ack_oe_a,
    output logic             cascade_ack_out_b,
    output logic             cascade_ack_oe_b,
    input  wire logic        cpu_ack,
    input  wire logic        cpu_ack_cycle,
    output logic             irq_req,
    output logic             ack_valid,
    output logic      [7:0]  ack_type,
    output logic      [9:0]  ack_vec_addr,
    output logic             ack_external
);
    import irq_resolver_pkg::*;

    logic [2:0]      prio_q [NCH];
    logic [6:0]      msk_q;
    logic [2:0]      pmask_q;
    logic [1:0]      cas_q;
    logic [1:0]      sfnm_q;
    logic [7:1]      req_q;
    logic [2:0]      tstat_q;
    logic [7:0]      isr_q;
    logic [NEXT-1:0] sy1_q;
    logic [NEXT-1:0] sy2_q;
    logic [NEXT-1:0] sy3_q;
    casc_state_t     cs_q;
    logic            csel_q;
    logic            irq_req_q;
    logic            ack_valid_q;
    logic [7:0]      ack_type_q;
    logic [9:0]      ack_vec_q;
    logic            ack_ext_q;
    logic            out_a_q;
    logic            out_b_q;
    logic            oe_a_q;
    logic            oe_b_q;
    logic [15:0]     rdata_q;

    logic [7:0]      req_v;
    logic [7:0]      qual;
    logic [7:0]      evt;
    logic [NEXT-1:0] ext_edge;
    logic            any_qual;
    logic [2:0]      win;
    logic [1:0]      tsel;
    logic            ack_take;
    logic            casc_hit;
    logic            hdone_wr;
    logic [2:0]      hdone_src;
    logic [2:0]      isr_best;
    logic [2:0]      ctl_ch;
    logic            ctl_wr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ============================================================
    // pin synchronisers and edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1_q <= '0;
            sy2_q <= '0;
            sy3_q <= '0;
        end else begin
            sy1_q <= {ext_irq_pin_d, ext_irq_pin_c, ext_irq_pin_b,
                      ext_irq_pin_a, ext_irq_pin_e};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    always_comb begin
        ext_edge = sy2_q & ~sy3_q;
        // pins turned into ack outputs no longer request
        ext_edge[3] = ext_edge[3] & ~cas_q[0];
        ext_edge[4] = ext_edge[4] & ~cas_q[1];
        evt = {ext_edge, ser_tx_evt, ser_rx_evt, 1'b0};
        req_v = {req_q, |tstat_q};
    end

    // ============================================================
    // priority resolution
    always_comb begin
        logic [2:0] p;
        logic [2:0] bp;
        logic       ok;
        p = 3'h0;
        bp = 3'h7;
        ok = 1'b0;
        qual = '0;
        win = 3'h0;
        any_qual = 1'b0;
        for (int s = 0; s < NSRC; s++) begin
            p = prio_q[chan_of(3'(s))];
            ok = req_v[s];
            ok = ok & ~msk_q[chan_of(3'(s))];
            ok = ok & (p < pmask_q);
            // the shared timer bit never nests, so it also blocks timers
            if (isr_q[s] && !((3'(s) == SRC_EXA && sfnm_q[0]) ||
                              (3'(s) == SRC_EXB && sfnm_q[1])))
                ok = 1'b0;
            for (int t = 0; t < NSRC; t++) begin
                if (isr_q[t] && p > prio_q[chan_of(3'(t))])
                    ok = 1'b0;
            end
            qual[s] = ok;
            // strict compare keeps the lower index on equal levels
            if (ok && (!any_qual || p < bp)) begin
                win = 3'(s);
                bp = p;
                any_qual = 1'b1;
            end
        end
    end

    always_comb begin
        tsel = tstat_q[0] ? 2'h0 : (tstat_q[1] ? 2'h1 : 2'h2);
        ack_take = cpu_ack && any_qual;
        casc_hit = (win == SRC_EXA && cas_q[0]) ||
                   (win == SRC_EXB && cas_q[1]);
    end

    // ============================================================
    // handler done command decode
    always_comb begin
        logic [2:0] bp;
        logic       hit;
        bp = 3'h7;
        hit = 1'b0;
        isr_best = 3'h0;
        for (int t = 0; t < NSRC; t++) begin
            if (isr_q[t] && (!hit || prio_q[chan_of(3'(t))] < bp)) begin
                isr_best = 3'(t);
                bp = prio_q[chan_of(3'(t))];
                hit = 1'b1;
            end
        end
        hdone_wr = reg_wr && reg_addr == OFS_HDONE;
        hdone_src = reg_wdata[HDONE_NSPC_BIT] ? isr_best : reg_wdata[2:0];
        ctl_wr = reg_wr && reg_addr >= OFS_CTL_BASE &&
                 reg_addr <= OFS_CTL_LAST && !reg_addr[0];
        ctl_ch = 3'((reg_addr - OFS_CTL_BASE) >> 1);
    end

    // ============================================================
    // pending requests
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;
        end else begin
            for (int s = 1; s < NSRC; s++) begin
                // a new event wins over the acknowledge clear
                if (evt[s])
                    req_q[s] <= 1'b1;
                else if (ack_take && win == 3'(s))
                    req_q[s] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tstat_q <= '0;
        end else begin
            for (int k = 0; k < NTMR; k++) begin
                if (tmr_evt[k])
                    tstat_q[k] <= 1'b1;
                else if (ack_take && win == SRC_TMR && tsel == 2'(k))
                    tstat_q[k] <= 1'b0;
            end
        end
    end

    // ============================================================
    // in-service tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            isr_q <= '0;
        end else begin
            for (int s = 0; s < NSRC; s++) begin
                if (ack_take && win == 3'(s))
                    isr_q[s] <= 1'b1;
                else if (hdone_wr && hdone_src == 3'(s))
                    isr_q[s] <= 1'b0;
            end
        end
    end

    // ============================================================
    // cpu side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req_q <= 1'b0;
            ack_valid_q <= 1'b0;
            ack_type_q <= '0;
            ack_vec_q <= '0;
            ack_ext_q <= 1'b0;
        end else begin
            irq_req_q <= any_qual;
            ack_valid_q <= ack_take;
            if (ack_take) begin
                ack_type_q <= type_of(win, tsel);
                ack_vec_q <= {type_of(win, tsel), 2'b00};
                ack_ext_q <= casc_hit;
            end
        end
    end

    // ============================================================
    // cascade acknowledge pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_q <= CS_IDLE;
            csel_q <= 1'b0;
        end else begin
            case (cs_q)
                CS_IDLE: begin
                    if (ack_take && casc_hit) begin
                        cs_q <= CS_ARMED;
                        csel_q <= (win == SRC_EXB);
                    end
                end
                CS_ARMED: begin
                    if (cpu_ack_cycle)
                        cs_q <= CS_DRIVE;
                end
                CS_DRIVE: begin
                    if (!cpu_ack_cycle)
                        cs_q <= CS_IDLE;
                end
                default: cs_q <= CS_IDLE;
            endcase
        end
    end

    // pins idle high so the far controller never sees a false ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_a_q <= 1'b1;
            out_b_q <= 1'b1;
            oe_a_q <= 1'b0;
            oe_b_q <= 1'b0;
        end else begin
            out_a_q <= !(cpu_ack_cycle && |cs_q && !csel_q);
            out_b_q <= !(cpu_ack_cycle && |cs_q && csel_q);
            oe_a_q <= cas_q[0];
            oe_b_q <= cas_q[1];
        end
    end

    // ============================================================
    // register file
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < NCH; c++)
                prio_q[c] <= PRIO_RST;
        end else if (ctl_wr) begin
            prio_q[ctl_ch] <= reg_wdata[CTL_PRIO_LSB +: 3];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            msk_q <= MSK_RST;
        else if (reg_wr && reg_addr == OFS_IMASK)
            msk_q <= reg_wdata[6:0];
        else if (ctl_wr)
            msk_q[ctl_ch] <= reg_wdata[CTL_MSK_BIT];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            pmask_q <= PMASK_RST;
        else if (reg_wr && reg_addr == OFS_PMASK)
            pmask_q <= reg_wdata[2:0];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cas_q <= '0;
            sfnm_q <= '0;
        end else if (ctl_wr && (ctl_ch == chan_of(SRC_EXA) ||
                                ctl_ch == chan_of(SRC_EXB))) begin
            cas_q[ctl_ch == chan_of(SRC_EXB)] <= reg_wdata[CTL_CAS_BIT];
            sfnm_q[ctl_ch == chan_of(SRC_EXB)] <= reg_wdata[CTL_SFNM_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    OFS_IMASK: rdata_q <= {9'h000, msk_q};
                    OFS_PMASK: rdata_q <= {13'h0000, pmask_q};
                    OFS_INSRV: rdata_q <= {8'h00, isr_q};
                    OFS_IREQ:  rdata_q <= {8'h00, req_v};
                    OFS_TSTAT: rdata_q <= {13'h0000, tstat_q};
                    default: begin
                        if (reg_addr >= OFS_CTL_BASE &&
                            reg_addr <= OFS_CTL_LAST && !reg_addr[0]) begin
                            rdata_q[CTL_PRIO_LSB +: 3] <= prio_q[ctl_ch];
                            rdata_q[CTL_MSK_BIT] <= msk_q[ctl_ch];
                            if (ctl_ch == chan_of(SRC_EXA)) begin
                                rdata_q[CTL_CAS_BIT] <= cas_q[0];
                                rdata_q[CTL_SFNM_BIT] <= sfnm_q[0];
                            end
                            if (ctl_ch == chan_of(SRC_EXB)) begin
                                rdata_q[CTL_CAS_BIT] <= cas_q[1];
                                rdata_q[CTL_SFNM_BIT] <= sfnm_q[1];
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign irq_req = irq_req_q;
    assign ack_valid = ack_valid_q;
    assign ack_type = ack_type_q;
    assign ack_vec_addr = ack_vec_q;
    assign ack_external = ack_ext_q;
    assign cascade_ack_out_a = out_a_q;
    assign cascade_ack_out_b = out_b_q;
    assign cascade_ack_oe_a = oe_a_q;
    assign cascade_ack_oe_b = oe_b_q;

    // ============================================================
    // checks
    tmr_status_a: assert property (tmr_evt[1] |=> tstat_q[1] && req_v[0])
        else $error("timer event lost");
    pend_hold_a: assert property (req_q[4] &&
        !(ack_take && win == SRC_EXA) |=> req_q[4])
        else $error("pending bit dropped");
    irq_cause_a: assert property ($rose(irq_req_q) |->
        $past(any_qual) && !$past(msk_q[chan_of(win)]))
        else $error("request raised without unmasked cause");
    pmask_gate_a: assert property (ack_take |->
        prio_q[chan_of(win)] < pmask_q)
        else $error("priority mask ignored");
    isr_set_a: assert property (ack_take && win == SRC_SRX |=>
        isr_q[1] && ack_valid_q && ack_type_q == TYPE_SRX)
        else $error("acknowledge bookkeeping wrong");
    tmr_block_a: assert property (isr_q[0] |-> !qual[0])
        else $error("timer nested on itself");
    vec_addr_a: assert property (ack_valid_q |->
        ack_vec_q == {ack_type_q, 2'b00})
        else $error("vector address not type times four");
    tmr_clear_a: assert property (ack_take && win == SRC_TMR &&
        $countones(tstat_q) == 1 && tmr_evt == 3'h0 |=> !req_v[0])
        else $error("shared timer request not cleared");
    cas_pin_a: assert property (!cas_q[0] |=> !oe_a_q && out_a_q)
        else $error("ack pin driven outside cascade");
endmodule // interrupt_priority_resolver

//--- test/cpu_partner.sv
// cpu-side model: takes the request, acknowledges, runs the external cycle
`timescale 1ns/1ps
module cpu_partner (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic go,
    input  wire logic irq_req,
    input  wire logic ack_valid,
    input  wire logic ack_external,
    output logic      cpu_ack,
    output logic      cpu_ack_cycle
);
    logic       armed_q;
    logic [2:0] cyc_q;
    // ============================================================
    // acknowledge
    // one pulse per go, because the request lags qualification by a cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            cpu_ack <= 1'b0;
        end else begin
            cpu_ack <= armed_q && irq_req && !cpu_ack;
            if (go) begin
                armed_q <= 1'b1;
            end else if (cpu_ack) begin
                armed_q <= 1'b0;
            end
        end
    end
    // ============================================================
    // external acknowledge cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_q <= 3'h0;
        end else if (ack_valid && ack_external) begin
            cyc_q <= 3'h5;
        end else if (cyc_q != 3'h0) begin
            cyc_q <= cyc_q - 3'h1;
        end
    end
    assign cpu_ack_cycle = (cyc_q != 3'h0) && (cyc_q <= 3'h3);
endmodule // cpu_partner

//--- test/tb_top.sv
// self-checking bench for the interrupt priority resolver
`timescale 1ns/1ps
module tb_top;
    logic        clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [2:0]  tmr_evt;
    logic [1:0]  ser_evt;
    logic [4:0]  ext_drv;
    logic        pin_c;
    logic        pin_d;
    logic        out_a;
    logic        oe_a;
    logic        out_b;
    logic        oe_b;
    logic        cpu_ack;
    logic        cpu_ack_cycle;
    logic        go;
    logic        irq_req;
    logic        ack_valid;
    logic        ack_external;
    logic [7:0]  ack_type;
    logic [9:0]  ack_vec_addr;
    int          n_fail;
    int          samples_checked;

    // pins c and d are driven from ext_drv; the device takes them over in cascade
    assign pin_c = oe_a ? out_a : ext_drv[2];
    assign pin_d = oe_b ? out_b : ext_drv[3];

    interrupt_priority_resolver interrupt_priority_resolver_i (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tmr_evt(tmr_evt),
        .ser_rx_evt(ser_evt[0]), .ser_tx_evt(ser_evt[1]),
        .ext_irq_pin_a(ext_drv[0]), .ext_irq_pin_b(ext_drv[1]),
        .ext_irq_pin_c(pin_c), .ext_irq_pin_d(pin_d),
        .ext_irq_pin_e(ext_drv[4]),
        .cascade_ack_out_a(out_a), .cascade_ack_oe_a(oe_a),
        .cascade_ack_out_b(out_b), .cascade_ack_oe_b(oe_b),
        .cpu_ack(cpu_ack), .cpu_ack_cycle(cpu_ack_cycle),
        .irq_req(irq_req), .ack_valid(ack_valid), .ack_type(ack_type),
        .ack_vec_addr(ack_vec_addr), .ack_external(ack_external)
    );

    cpu_partner cpu_partner_i (
        .clk(clk), .rst_n(rst_n), .go(go), .irq_req(irq_req),
        .ack_valid(ack_valid), .ack_external(ack_external),
        .cpu_ack(cpu_ack), .cpu_ack_cycle(cpu_ack_cycle)
    );

    // ============================================================
    // helpers
    task automatic complete_run;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // pins pass a two-stage synchroniser before the edge detector
    task automatic pin(input int i, input logic v);
        @(posedge clk);
        ext_drv[i] <= v;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic evt(input logic [2:0] t, input logic [1:0] s);
        @(posedge clk);
        tmr_evt <= t;
        ser_evt <= s;
        @(posedge clk);
        tmr_evt <= 3'h0;
        ser_evt <= 2'h0;
        settle();
    endtask

    task automatic ack(input logic [7:0] t, input logic x);
        int n;
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ack_valid !== 1'b1 && n < 20);
        chk(16'(ack_valid), 16'h0001);
        chk(16'(ack_type), 16'(t));
        chk(16'(ack_vec_addr), 16'({t, 2'b00}));
        chk(16'(ack_external), 16'(x));
    endtask

    task automatic wait_cycle(input logic v);
        int n;
        n = 0;
        while (cpu_ack_cycle !== v && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
    endtask

    // ============================================================
    // clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000;
        reg_wr = 1'b0; reg_rd = 1'b0; tmr_evt = 3'h0; ser_evt = 2'h0;
        ext_drv = 5'h00; go = 1'b0; n_fail = 0; samples_checked = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'h18, 16'h000F);
        rdchk(8'h08, 16'h007F);
        rdchk(8'h0A, 16'h0007);
        rdchk(8'h09, 16'h0000);
        chk(16'(oe_a), 16'h0000);
        chk(16'(out_a), 16'h0001);
        wr(8'h18, 16'h000A);
        pin(0, 1'b1);
        chk(16'(irq_req), 16'h0000);
        rdchk(8'h0E, 16'h0010);
        wr(8'h18, 16'h0007);
        settle();
        chk(16'(irq_req), 16'h0000);
        wr(8'h18, 16'h0002);
        settle();
        chk(16'(irq_req), 16'h0001);
        ack(8'h0C, 1'b0);
        rdchk(8'h0C, 16'h0010);
        rdchk(8'h0E, 16'h0000);
        pin(0, 1'b0);
        wr(8'h1E, 16'h0005);
        pin(3, 1'b1);
        chk(16'(irq_req), 16'h0000);
        wr(8'h02, 16'h8000);
        settle();
        chk(16'(irq_req), 16'h0001);
        ack(8'h0F, 1'b0);
        wr(8'h02, 16'h0007);
        rdchk(8'h0C, 16'h0000);
        pin(3, 1'b0);
        wr(8'h12, 16'h0001);
        evt(3'h6, 2'h0);
        rdchk(8'h10, 16'h0006);
        ack(8'h12, 1'b0);
        rdchk(8'h10, 16'h0004);
        rdchk(8'h0E, 16'h0001);
        evt(3'h1, 2'h0);
        chk(16'(irq_req), 16'h0000);
        wr(8'h02, 16'h0000);
        ack(8'h08, 1'b0);
        wr(8'h02, 16'h0000);
        ack(8'h13, 1'b0);
        rdchk(8'h0E, 16'h0000);
        wr(8'h02, 16'h0000);
        wr(8'h14, 16'h0003);
        evt(3'h0, 2'h3);
        ack(8'h14, 1'b0);
        ack(8'h15, 1'b0);
        wr(8'h02, 16'h8000);
        wr(8'h02, 16'h8000);
        rdchk(8'h0C, 16'h0000);
        wr(8'h18, 16'h0062);
        settle();
        chk(16'(oe_a), 16'h0001);
        chk(16'(out_a), 16'h0001);
        pin(0, 1'b1);
        ack(8'h0C, 1'b1);
        wait_cycle(1'b1);
        chk(16'(out_a), 16'h0000);
        wait_cycle(1'b0);
        chk(16'(out_a), 16'h0001);
        pin(0, 1'b0);
        pin(0, 1'b1);
        ack(8'h0C, 1'b1);
        wr(8'h02, 16'h0004);
        wr(8'h1A, 16'h0042);
        pin(1, 1'b1);
        ack(8'h0D, 1'b0);
        pin(1, 1'b0);
        pin(1, 1'b1);
        ack(8'h0D, 1'b0);
        chk(16'(oe_b), 16'h0000);
        chk(16'(out_b), 16'h0001);
        wr(8'h1A, 16'h0062);
        pin(1, 1'b0);
        pin(1, 1'b1);
        ack(8'h0D, 1'b1);
        wait_cycle(1'b1);
        chk(16'(out_b), 16'h0000);
        wait_cycle(1'b0);
        chk(16'(out_b), 16'h0001);
        chk(16'(oe_b), 16'h0001);
        wr(8'h16, 16'h0001);
        pin(4, 1'b1);
        ack(8'h11, 1'b0);
        repeat (10) @(posedge clk);
        complete_run();
    end
endmodule // tb_top
